// *** rtl/mscr_regs.svh ***
// Register offsets, field positions and reset values of the start-up config bank.
// Included by the package and the register bank; definitions only.
`ifndef MSCR_REGS_SVH
`define MSCR_REGS_SVH

// Printed register indices; byte address is four times the index
`define MSCR_IDX_CFG_A 12'h085
`define MSCR_IDX_CFG_B 12'h086
`define MSCR_IDX_STATUS 12'h087
`define MSCR_ADDR_CFG_A 12'h214
`define MSCR_ADDR_CFG_B 12'h218
`define MSCR_ADDR_STATUS 12'h21C
`define MSCR_ADDR_W 12

// Reset values
`define MSCR_RST_CFG_A 32'h00000000
`define MSCR_RST_CFG_B 32'h00000000
// Decoded outputs while the config registers hold zero
`define MSCR_RST_CAP 6'h01
`define MSCR_RST_LIN 20'h00001
`define MSCR_RST_THR 7'h02

// Writable bit masks
`define MSCR_WMASK_CFG_A 32'h00000003
`define MSCR_WMASK_CFG_B 32'h7FFFFFFF

// Config A fields
`define MSCR_A_SRC_SEL 0
`define MSCR_A_BRAKE_EN 1

// Config B fields
`define MSCR_B_CAP_HI 30
`define MSCR_B_CAP_LO 27
`define MSCR_B_LIN_HI 26
`define MSCR_B_LIN_LO 23
`define MSCR_B_QUAD_HI 22
`define MSCR_B_QUAD_LO 19
`define MSCR_B_AUTO 18
`define MSCR_B_THR_HI 17
`define MSCR_B_THR_LO 13
`define MSCR_B_LOW_HI 12
`define MSCR_B_LOW_LO 0

// Status fields
`define MSCR_S_CAP_RSVD 0
`define MSCR_S_AUTO 1
`define MSCR_S_REV_SRC 2
`define MSCR_S_BRAKE 3

// Current cap codes at and above this value are reserved
`define MSCR_CAP_RSVD_CODE 4'hE
// Threshold code where the step changes from 1 % to 2.5 %
`define MSCR_THR_KNEE 5'h14
`define MSCR_THR_KNEE_VAL 7'h2D
`define MSCR_THR_FINE_STEP 7'h02
`define MSCR_THR_COARSE_STEP 7'h05

`endif

// *** rtl/mscr_pkg.sv ***
// Types shared by the start-up config register bank.
// Assumes mscr_regs.svh on the include path.
`include "mscr_regs.svh"

package mscr_pkg;
  typedef logic [31:0] mscr_word_type;
  typedef logic [`MSCR_ADDR_W-1:0] mscr_addr_type;
  typedef enum logic [1:0] {
    MSCR_RESP_OKAY = 2'b00,
    MSCR_RESP_SLVERR = 2'b10
  } mscr_resp_type;
  typedef logic [5:0] mscr_cap_type;
  typedef logic [19:0] mscr_accel_type;
  typedef logic [6:0] mscr_thr_type;
endpackage

// *** rtl/mscr_top.sv ***
// Start-up configuration register bank with AXI4-Lite slave and decoded outputs.
// Assumes a single 50 MHz clock, synchronous inputs and a well-behaved AXI master.
//
// Notes on behaviour
// - Brake enable bit gates reverse-drive braking
// - Source bit picks forward or reverse settings
// - Config B at index 86h, resets zero
// - Current cap codes 0-Dh decode; Eh/Fh reserved
// - Linear acceleration sixteen codes decoded
// - Quadratic acceleration sixteen codes decoded
// - Bit 18 selects threshold or automatic handoff
// - Threshold code gives percent of max speed
//
// Chosen here: register access over AXI4-Lite.
`timescale 1ns/1ps
`default_nettype none
`include "mscr_regs.svh"

module mscr_top (
  // Clock, reset, enable
  input wire logic i_clk,
  input wire logic i_rst_n,
  input wire logic i_ce,
  // AXI4-Lite write address and data
  input wire logic i_awvalid,
  output logic o_awready,
  input wire mscr_pkg::mscr_addr_type i_awaddr,
  input wire logic [2:0] i_awprot,
  input wire logic i_wvalid,
  output logic o_wready,
  input wire mscr_pkg::mscr_word_type i_wdata,
  input wire logic [3:0] i_wstrb,
  // AXI4-Lite write response
  output logic o_bvalid,
  input wire logic i_bready,
  output logic [1:0] o_bresp,
  // AXI4-Lite read
  input wire logic i_arvalid,
  output logic o_arready,
  input wire mscr_pkg::mscr_addr_type i_araddr,
  input wire logic [2:0] i_arprot,
  output logic o_rvalid,
  input wire logic i_rready,
  output mscr_pkg::mscr_word_type o_rdata,
  output logic [1:0] o_rresp,
  // Decoded settings to the start-up engine
  output logic o_brake_enable,
  output logic o_reverse_drive_source_sel,
  output mscr_pkg::mscr_cap_type o_open_loop_current_cap,
  output logic o_current_cap_reserved,
  output mscr_pkg::mscr_accel_type o_open_loop_linear_accel,
  output mscr_pkg::mscr_accel_type o_open_loop_quadratic_accel,
  output logic o_auto_handoff,
  output mscr_pkg::mscr_thr_type o_loop_transfer_speed_level
);
  import mscr_pkg::*;

  // Byte-lane merge under write strobes and a writable mask
  function automatic mscr_word_type merge(input mscr_word_type old_v, input mscr_word_type new_v,
                                          input logic [3:0] strb, input mscr_word_type wmask);
    mscr_word_type r;
    r = old_v;
    for (int i = 0; i < 4; i++) begin
      if (strb[i]) begin
        r[8*i +: 8] = new_v[8*i +: 8];
      end
    end
    merge = r & wmask;
  endfunction
  // Current cap in steps of 0.078125 A; doubles up to code 2, then steps of four
  function automatic mscr_cap_type cap_decode(input logic [3:0] c);
    if (c >= `MSCR_CAP_RSVD_CODE) begin
      cap_decode = 6'h00;
    end else if (c < 4'h3) begin
      cap_decode = 6'h01 << c;
    end else begin
      cap_decode = {2'b00, c - 4'h1} << 2;
    end
  endfunction
  // Acceleration in steps of 0.01 Hz/s (or Hz/s2); code 0 differs per field
  function automatic mscr_accel_type accel_decode(input logic [3:0] c, input mscr_accel_type zero_val);
    case (c)
      4'h0: accel_decode = zero_val;
      4'h1: accel_decode = 20'h00005;
      4'h2: accel_decode = 20'h00064;
      4'h3: accel_decode = 20'h000FA;
      4'h4: accel_decode = 20'h001F4;
      4'h5: accel_decode = 20'h003E8;
      4'h6: accel_decode = 20'h009C4;
      4'h7: accel_decode = 20'h01388;
      4'h8: accel_decode = 20'h01D4C;
      4'h9: accel_decode = 20'h02710;
      4'hA: accel_decode = 20'h061A8;
      4'hB: accel_decode = 20'h0C350;
      4'hC: accel_decode = 20'h124F8;
      4'hD: accel_decode = 20'h186A0;
      4'hE: accel_decode = 20'h7A120;
      default: accel_decode = 20'hF4240;
    endcase
  endfunction

  // Threshold in steps of 0.5 % of max speed
  function automatic mscr_thr_type thr_decode(input logic [4:0] c);
    mscr_thr_type n;
    n = {2'b00, c};
    if (c < `MSCR_THR_KNEE) begin
      thr_decode = 7'((n + 7'h01) * `MSCR_THR_FINE_STEP);
    end else begin
      thr_decode = 7'(`MSCR_THR_KNEE_VAL + (n - {2'b00, `MSCR_THR_KNEE}) * `MSCR_THR_COARSE_STEP);
    end
  endfunction
  // Register group
  mscr_word_type cfg_a_reg, cfg_a_next;
  mscr_word_type cfg_b_reg, cfg_b_next;
  // Write channel group
  logic awready_reg, awready_next;
  logic wready_reg, wready_next;
  logic aw_held_reg, aw_held_next;
  logic w_held_reg, w_held_next;
  mscr_addr_type waddr_reg, waddr_next;
  mscr_word_type wdata_reg, wdata_next;
  logic [3:0] wstrb_reg, wstrb_next;
  logic bvalid_reg, bvalid_next;
  logic [1:0] bresp_reg, bresp_next;
  // Read channel group
  logic arready_reg, arready_next;
  logic rvalid_reg, rvalid_next;
  mscr_word_type rdata_reg, rdata_next;
  logic [1:0] rresp_reg, rresp_next;
  // Decoded output group
  logic brake_reg, brake_next;
  logic src_reg, src_next;
  mscr_cap_type cap_reg, cap_next;
  logic cap_rsvd_reg, cap_rsvd_next;
  mscr_accel_type lin_reg, lin_next;
  mscr_accel_type quad_reg, quad_next;
  logic auto_reg, auto_next;
  mscr_thr_type thr_reg, thr_next;
  logic commit;
  mscr_word_type status_word;
  always_comb begin
    status_word = 32'h00000000;
    status_word[`MSCR_S_CAP_RSVD] = cap_rsvd_reg;
    status_word[`MSCR_S_AUTO] = auto_reg;
    status_word[`MSCR_S_REV_SRC] = src_reg;
    status_word[`MSCR_S_BRAKE] = brake_reg;
  end
  // AXI write path: address and data taken in either order
  always_comb begin
    aw_held_next = aw_held_reg;
    w_held_next = w_held_reg;
    waddr_next = waddr_reg;
    wdata_next = wdata_reg;
    wstrb_next = wstrb_reg;
    bvalid_next = bvalid_reg;
    bresp_next = bresp_reg;
    cfg_a_next = cfg_a_reg;
    cfg_b_next = cfg_b_reg;
    commit = aw_held_reg && w_held_reg && !bvalid_reg;
    if (i_awvalid && awready_reg) begin
      aw_held_next = 1'b1;
      waddr_next = i_awaddr;
    end
    if (i_wvalid && wready_reg) begin
      w_held_next = 1'b1;
      wdata_next = i_wdata;
      wstrb_next = i_wstrb;
    end
    if (bvalid_reg && i_bready) begin
      bvalid_next = 1'b0;
    end
    if (commit) begin
      aw_held_next = 1'b0;
      w_held_next = 1'b0;
      bvalid_next = 1'b1;
      bresp_next = MSCR_RESP_OKAY;
      case (waddr_reg)
        `MSCR_ADDR_CFG_A: cfg_a_next = merge(cfg_a_reg, wdata_reg, wstrb_reg, `MSCR_WMASK_CFG_A);
        `MSCR_ADDR_CFG_B: cfg_b_next = merge(cfg_b_reg, wdata_reg, wstrb_reg, `MSCR_WMASK_CFG_B);
        `MSCR_ADDR_STATUS: bresp_next = MSCR_RESP_OKAY;
        default: bresp_next = MSCR_RESP_SLVERR;
      endcase
    end
    awready_next = !aw_held_next && !bvalid_next;
    wready_next = !w_held_next && !bvalid_next;
  end
  // AXI read path
  always_comb begin
    rvalid_next = rvalid_reg;
    rdata_next = rdata_reg;
    rresp_next = rresp_reg;
    if (rvalid_reg && i_rready) begin
      rvalid_next = 1'b0;
    end
    if (i_arvalid && arready_reg) begin
      rvalid_next = 1'b1;
      rresp_next = MSCR_RESP_OKAY;
      case (i_araddr)
        `MSCR_ADDR_CFG_A: rdata_next = cfg_a_reg;
        `MSCR_ADDR_CFG_B: rdata_next = cfg_b_reg & `MSCR_WMASK_CFG_B;
        `MSCR_ADDR_STATUS: rdata_next = status_word;
        default: begin
          rdata_next = 32'h00000000;
          rresp_next = MSCR_RESP_SLVERR;
        end
      endcase
    end
    arready_next = !rvalid_next;
  end
  // Decode settings for the start-up engine
  always_comb begin
    brake_next = cfg_a_reg[`MSCR_A_BRAKE_EN];
    src_next = cfg_a_reg[`MSCR_A_SRC_SEL];
    cap_next = cap_decode(cfg_b_reg[`MSCR_B_CAP_HI:`MSCR_B_CAP_LO]);
    cap_rsvd_next = cfg_b_reg[`MSCR_B_CAP_HI:`MSCR_B_CAP_LO] >= `MSCR_CAP_RSVD_CODE;
    lin_next = accel_decode(cfg_b_reg[`MSCR_B_LIN_HI:`MSCR_B_LIN_LO], 20'h00001);
    quad_next = accel_decode(cfg_b_reg[`MSCR_B_QUAD_HI:`MSCR_B_QUAD_LO], 20'h00000);
    auto_next = cfg_b_reg[`MSCR_B_AUTO];
    thr_next = thr_decode(cfg_b_reg[`MSCR_B_THR_HI:`MSCR_B_THR_LO]);
  end
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      cfg_a_reg <= `MSCR_RST_CFG_A;
      cfg_b_reg <= `MSCR_RST_CFG_B;
      awready_reg <= 1'b0;
      wready_reg <= 1'b0;
      aw_held_reg <= 1'b0;
      w_held_reg <= 1'b0;
      waddr_reg <= 12'h000;
      wdata_reg <= 32'h00000000;
      wstrb_reg <= 4'h0;
      bvalid_reg <= 1'b0;
      bresp_reg <= 2'h0;
      arready_reg <= 1'b0;
      rvalid_reg <= 1'b0;
      rdata_reg <= 32'h00000000;
      rresp_reg <= 2'h0;
      brake_reg <= 1'b0;
      src_reg <= 1'b0;
      cap_reg <= `MSCR_RST_CAP;
      cap_rsvd_reg <= 1'b0;
      lin_reg <= `MSCR_RST_LIN;
      quad_reg <= 20'h00000;
      auto_reg <= 1'b0;
      thr_reg <= `MSCR_RST_THR;
    end else if (i_ce) begin
      cfg_a_reg <= cfg_a_next;
      cfg_b_reg <= cfg_b_next;
      awready_reg <= awready_next;
      wready_reg <= wready_next;
      aw_held_reg <= aw_held_next;
      w_held_reg <= w_held_next;
      waddr_reg <= waddr_next;
      wdata_reg <= wdata_next;
      wstrb_reg <= wstrb_next;
      bvalid_reg <= bvalid_next;
      bresp_reg <= bresp_next;
      arready_reg <= arready_next;
      rvalid_reg <= rvalid_next;
      rdata_reg <= rdata_next;
      rresp_reg <= rresp_next;
      brake_reg <= brake_next;
      src_reg <= src_next;
      cap_reg <= cap_next;
      cap_rsvd_reg <= cap_rsvd_next;
      lin_reg <= lin_next;
      quad_reg <= quad_next;
      auto_reg <= auto_next;
      thr_reg <= thr_next;
    end
  end

  assign o_awready = awready_reg;
  assign o_wready = wready_reg;
  assign o_bvalid = bvalid_reg;
  assign o_bresp = bresp_reg;
  assign o_arready = arready_reg;
  assign o_rvalid = rvalid_reg;
  assign o_rdata = rdata_reg;
  assign o_rresp = rresp_reg;
  assign o_brake_enable = brake_reg;
  assign o_reverse_drive_source_sel = src_reg;
  assign o_open_loop_current_cap = cap_reg;
  assign o_current_cap_reserved = cap_rsvd_reg;
  assign o_open_loop_linear_accel = lin_reg;
  assign o_open_loop_quadratic_accel = quad_reg;
  assign o_auto_handoff = auto_reg;
  assign o_loop_transfer_speed_level = thr_reg;
  // Protection bits are accepted but carry no meaning here
  logic unused_prot;
  assign unused_prot = ^{i_awprot, i_arprot};
endmodule

`default_nettype wire

// *** verif/mscr_top_asserts.sv ***
// Concurrent checks on the start-up config bank ports.
// Bound into mscr_top; one clock, async active-low reset.
`timescale 1ns/1ps
`default_nettype none
`include "mscr_regs.svh"
module mscr_asserts (
  // Clock and reset
  input wire logic i_clk,
  input wire logic i_rst_n,
  // Bus
  input wire logic i_awvalid,
  input wire logic o_awready,
  input wire logic i_wvalid,
  input wire logic o_wready,
  input wire logic o_bvalid,
  input wire logic i_arvalid,
  input wire logic o_arready,
  input wire mscr_pkg::mscr_addr_type i_araddr,
  input wire logic o_rvalid,
  input wire mscr_pkg::mscr_word_type o_rdata,
  // Settings
  input wire logic o_brake_enable,
  input wire logic o_reverse_drive_source_sel,
  input wire mscr_pkg::mscr_cap_type o_open_loop_current_cap,
  input wire logic o_current_cap_reserved,
  input wire logic o_auto_handoff,
  input wire mscr_pkg::mscr_thr_type o_loop_transfer_speed_level
);
  import mscr_pkg::*;
  mscr_addr_type ar_reg;
  mscr_addr_type ar_next;
  // Address of the read in flight
  always_comb ar_next = (i_arvalid && o_arready) ? i_araddr : ar_reg;
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) ar_reg <= '0;
    else ar_reg <= ar_next;
  end
  default clocking @(posedge i_clk); endclocking
  default disable iff (!i_rst_n);
  a_cap_rsvd: assert property (o_current_cap_reserved |-> o_open_loop_current_cap == 6'h00)
    else $error("cap nonzero on reserved code");
  a_thr_range: assert property (o_loop_transfer_speed_level inside {[7'h02:7'h64]})
    else $error("threshold out of range");
  a_b31_zero: assert property (o_rvalid && ar_reg == `MSCR_ADDR_CFG_B |-> !o_rdata[31])
    else $error("config b bit 31 read as one");
  a_brake_chg: assert property ($changed(o_brake_enable) |-> $past(o_bvalid))
    else $error("brake changed without write");
  a_src_chg: assert property ($changed(o_reverse_drive_source_sel) |-> $past(o_bvalid))
    else $error("source select changed without write");
  a_auto_chg: assert property ($changed(o_auto_handoff) |-> $past(o_bvalid))
    else $error("auto handoff changed without write");
  a_wr_lat: assert property (i_awvalid && o_awready && i_wvalid && o_wready |-> ##2 o_bvalid)
    else $error("write response late");
  a_rd_lat: assert property (i_arvalid && o_arready |=> o_rvalid)
    else $error("read data late");
endmodule
bind mscr_top mscr_asserts u_chk (.*);
`default_nettype wire

// *** verif/mscr_top_tb.sv ***
// Self-checking bench for the start-up config bank.
// Drives the AXI4-Lite port itself; 50 MHz clock.
`timescale 1ns/1ps
`default_nettype none
`include "mscr_regs.svh"
module mscr_top_tb;
  import mscr_pkg::*;
  logic i_clk = 1'b0;
  logic i_rst_n = 1'b0;
  logic i_awvalid = 1'b0, i_wvalid = 1'b0, i_bready = 1'b0, i_arvalid = 1'b0, i_rready = 1'b0;
  mscr_addr_type i_awaddr = '0, i_araddr = '0;
  mscr_word_type i_wdata = '0, rd, o_rdata;
  logic [3:0] i_wstrb = 4'hF;
  logic o_awready, o_wready, o_bvalid, o_arready, o_rvalid, o_brake_enable, o_reverse_drive_source_sel;
  logic o_current_cap_reserved, o_auto_handoff;
  logic [1:0] o_bresp, o_rresp, rsp;
  mscr_cap_type o_open_loop_current_cap;
  mscr_accel_type o_open_loop_linear_accel, o_open_loop_quadratic_accel;
  mscr_thr_type o_loop_transfer_speed_level;
  int num_errors = 0, total_checks = 0;
  int lin_tab [16] = '{1, 5, 100, 250, 500, 1000, 2500, 5000, 7500, 10000, 25000, 50000, 75000, 100000,
    500000, 1000000};
  mscr_top dut (.i_ce(1'b1), .i_awprot(3'h0), .i_arprot(3'h0), .*);
  initial begin
    forever #10 i_clk = ~i_clk;
  end
  task automatic chk(input string n, input mscr_word_type g, input mscr_word_type e);
    total_checks++;
    if (g !== e) begin
      num_errors++;
      $display("[FAIL] %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic print_verdict();
    $display("checks %0d mismatches %0d", total_checks, num_errors);
    if (num_errors == 0 && total_checks > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  task automatic hang(input int n);
    if (n >= 40) begin
      num_errors++;
      $display("[FAIL] handshake expected done seen timeout");
      print_verdict();
    end
  endtask
  task automatic wr(input mscr_addr_type a, input mscr_word_type d, input logic [3:0] s);
    int n;
    @(posedge i_clk);
    i_awaddr <= a;
    i_wdata <= d;
    i_wstrb <= s;
    i_awvalid <= 1'b1;
    i_wvalid <= 1'b1;
    i_bready <= 1'b1;
    for (n = 0; n < 40; n++) begin
      @(posedge i_clk);
      if (o_awready) i_awvalid <= 1'b0;
      if (o_wready) i_wvalid <= 1'b0;
      if (o_bvalid) break;
    end
    hang(n);
    rsp = o_bresp;
    i_bready <= 1'b0;
    #1;
  endtask
  task automatic rdt(input mscr_addr_type a);
    int n;
    @(posedge i_clk);
    i_araddr <= a;
    i_arvalid <= 1'b1;
    i_rready <= 1'b1;
    for (n = 0; n < 40; n++) begin
      @(posedge i_clk);
      if (o_arready) i_arvalid <= 1'b0;
      if (o_rvalid) break;
    end
    hang(n);
    rd = o_rdata;
    rsp = o_rresp;
    i_rready <= 1'b0;
    #1;
  endtask
  task automatic t_reset();
    #1;
    chk("rst_out", {o_brake_enable, o_reverse_drive_source_sel, o_auto_handoff, o_current_cap_reserved,
      o_open_loop_current_cap, o_loop_transfer_speed_level}, {4'h0, 6'h01, 7'h02});
    chk("rst_lin", o_open_loop_linear_accel, 32'h1);
    chk("rst_quad", o_open_loop_quadratic_accel, 32'h0);
    rdt(`MSCR_ADDR_CFG_B);
    chk("rst_b", rd, 32'h0);
    $display("test reset done");
  endtask
  task automatic t_cfg_a();
    for (int v = 0; v < 4; v++) begin
      wr(`MSCR_ADDR_CFG_A, 32'hFFFFFFFC | v, 4'hF);
      chk("brake", o_brake_enable, v[1]);
      chk("src", o_reverse_drive_source_sel, v[0]);
      rdt(`MSCR_ADDR_CFG_A);
      chk("cfg_a", rd, v);
    end
    $display("test config a done");
  endtask
  task automatic t_cap();
    for (int c = 0; c < 16; c++) begin
      wr(`MSCR_ADDR_CFG_B, c << 27, 4'hF);
      chk("cap", o_open_loop_current_cap, c == 0 ? 1 : c == 1 ? 2 : c < 14 ? 4 * (c - 1) : 0);
      chk("cap_rsvd", o_current_cap_reserved, c > 13);
    end
    $display("test current cap done");
  endtask
  task automatic t_acc();
    for (int c = 0; c < 16; c++) begin
      wr(`MSCR_ADDR_CFG_B, (c << 23) | (c << 19), 4'hF);
      chk("lin", o_open_loop_linear_accel, lin_tab[c]);
      chk("quad", o_open_loop_quadratic_accel, c == 0 ? 0 : lin_tab[c]);
    end
    $display("test accel done");
  endtask
  task automatic t_thr();
    for (int c = 0; c < 32; c++) begin
      wr(`MSCR_ADDR_CFG_B, (c << 13) | ((c & 1) << 18), 4'hF);
      chk("thr", o_loop_transfer_speed_level, c < 20 ? 2 * c + 2 : 5 * c - 55);
      chk("auto", o_auto_handoff, c & 1);
    end
    $display("test handoff done");
  endtask
  task automatic t_misc();
    wr(`MSCR_ADDR_CFG_B, 32'hFFFFFFFF, 4'hF);
    chk("wr_ok", rsp, 2'b00);
    rdt(`MSCR_ADDR_CFG_B);
    chk("b_all", rd, 32'h7FFFFFFF);
    chk("rd_ok", rsp, 2'b00);
    wr(`MSCR_ADDR_CFG_B, 32'h0, 4'h8);
    rdt(`MSCR_ADDR_CFG_B);
    chk("b_lane", rd, 32'h00FFFFFF);
    wr(`MSCR_ADDR_STATUS, 32'h0, 4'hF);
    chk("wr_status", rsp, 2'b00);
    rdt(`MSCR_ADDR_STATUS);
    chk("status", rd, 32'h0000000E);
    wr(12'h300, 32'h0, 4'hF);
    chk("wr_err", rsp, 2'b10);
    rdt(12'h300);
    chk("rd_err", rsp, 2'b10);
    chk("rd_err_data", rd, 32'h0);
    $display("test access done");
  endtask
  task automatic t_rst_mid();
    @(posedge i_clk);
    i_rst_n <= 1'b0;
    repeat (2) @(posedge i_clk);
    i_rst_n <= 1'b1;
    #1;
    chk("rst2_out", {o_brake_enable, o_auto_handoff}, 2'b00);
    rdt(`MSCR_ADDR_CFG_B);
    chk("rst2_b", rd, 32'h0);
    $display("test second reset done");
  endtask
  initial begin
    repeat (8) @(posedge i_clk);
    i_rst_n <= 1'b1;
    t_reset();
    t_cfg_a();
    t_cap();
    t_acc();
    t_thr();
    t_misc();
    t_rst_mid();
    print_verdict();
  end
endmodule
`default_nettype wire
